// *** tb/brm_bank_properties.sv ***
`timescale 1ns/10ps
`include "brm_params.svh"
module brm_bank_properties
  import brm_pkg::*;
(
  // clock and reset
  input wire logic              clock,
  input wire logic              rst,
  // request and answer
  input wire logic              req_valid,
  input brm_pkg::brm_req_type   req,
  input wire logic              req_ready,
  input wire logic              req_reject,
  input brm_pkg::brm_byte_type  rsp,
  input wire logic              rsp_ready,
  // status
  input brm_pkg::brm_status_type status,
  input wire logic              temp_unit_f
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic good;
  // only the two read functions with a nonzero count are served
  assign good = (req.func == `BRM_FC_READ_HOLDING || req.func == `BRM_FC_READ_INPUT) && req.count != 8'h00;
  sequence s_take;
    req_valid && req_ready && good;
  endsequence
  sequence s_first;
    ##1 !rsp.valid [*2] ##1 rsp.valid && !rsp.last;
  endsequence
  property p_refuse;
    req_valid && req_ready && !good |-> req_reject;
  endproperty
  property p_accept;
    s_take |-> !req_reject ##1 !req_ready;
  endproperty
  property p_first;
    s_take |-> s_first;
  endproperty
  property p_hold;
    rsp.valid && !rsp_ready |=> rsp.valid && $stable(rsp.data) && $stable(rsp.last);
  endproperty
  property p_pair;
    rsp.valid && rsp_ready && !rsp.last |=> ##[0:2] rsp.valid;
  endproperty
  property p_busy;
    rsp.valid |-> !req_ready;
  endproperty
  property p_end;
    rsp.valid && rsp.last && rsp_ready |=> req_ready && !rsp.valid;
  endproperty
  property p_unit;
    temp_unit_f == status.temp_unit_f;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad request not refused");
  a_accept: assert property (p_accept) else $error("good request refused");
  a_first: assert property (p_first) else $error("first byte late");
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  a_pair: assert property (p_pair) else $error("next byte missing");
  a_busy: assert property (p_busy) else $error("ready while answering");
  a_end: assert property (p_end) else $error("no idle after last byte");
  a_unit: assert property (p_unit) else $error("unit flag wrong");
endmodule : brm_bank_properties

bind brm_register_bank brm_bank_properties chk_u (.clock, .rst, .req_valid, .req, .req_ready,
  .req_reject, .rsp, .rsp_ready, .status, .temp_unit_f);

// *** tb/brm_master_model.sv ***
`timescale 1ns/10ps
module brm_master_model
  import brm_pkg::*;
(
  // clock and pacing
  input wire logic             clock,
  input wire logic             slow,
  // request side
  output logic                 req_valid,
  output brm_pkg::brm_req_type req,
  input wire logic             req_ready,
  input wire logic             req_reject,
  // answer side
  output logic                 rsp_ready,
  input brm_pkg::brm_byte_type rsp
);
  logic [1:0] cnt_reg = 2'h0;
  logic [7:0] got[$];
  logic       rej_seen;
  logic [7:0] last_at;
  initial req_valid = 1'b0;
  initial req = '0;
  // slow mode takes one byte in four, so the bank must hold its bytes
  always_ff @(posedge clock) cnt_reg <= cnt_reg + 2'h1;
  assign rsp_ready = !slow || cnt_reg == 2'h0;
  // one read: request held until taken, then bytes gathered
  task automatic read(input logic [7:0] f, input logic [15:0] s, input logic [7:0] n);
    int k;
    got.delete();
    k = 0;
    last_at = 8'h00;
    req_valid <= 1'b1;
    req <= '{f, s, n};
    @(posedge clock iff req_ready);
    rej_seen = req_reject;
    req_valid <= 1'b0;
    req <= ~req; // released lines do not keep the last value
    // a refused request leaves one idle edge before the next one
    if (rej_seen) @(posedge clock);
    while (!rej_seen && got.size() < 2 * n && k < 400) begin
      @(posedge clock);
      k++;
      if (rsp.valid && rsp_ready) begin
        got.push_back(rsp.data);
        if (rsp.last) last_at = 8'(got.size());
      end
    end
  endtask : read
endmodule : brm_master_model

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`include "brm_params.svh"
module testbench;
  import brm_pkg::*;
  logic clock, rst, slow, req_valid, req_ready, req_reject, rsp_ready, temp_unit_f, temp_wr;
  brm_req_type req;
  brm_byte_type rsp;
  brm_status_type status;
  logic [15:0] process_temp, process_sp, low_fire_sp, pilot_off_sp, low_temp_sp, high_temp_sp, temp_val;
  logic [4:0] temp_idx;
  logic [63:0] pilot_flame, main_flame;
  int num_errors = 0;
  int check_count = 0;
  brm_register_bank dut_u (.clock, .rst, .req_valid, .req, .req_ready, .req_reject, .rsp, .rsp_ready,
    .status, .process_temp, .process_sp, .low_fire_sp, .pilot_off_sp, .low_temp_sp, .high_temp_sp,
    .temp_wr, .temp_idx, .temp_val, .pilot_flame, .main_flame, .temp_unit_f);
  brm_master_model partner_u (.clock, .slow, .req_valid, .req, .req_ready, .req_reject, .rsp_ready, .rsp);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  // read registers and compare byte count and every byte
  task automatic rd(input logic [7:0] f, input logic [15:0] s, input logic [15:0] e[$]);
    partner_u.read(f, s, 8'(e.size()));
    cmp8(8'(partner_u.got.size()), 8'(2 * e.size()));
    cmp8(partner_u.last_at, 8'(2 * e.size()));
    foreach (e[i]) begin
      cmp8(partner_u.got[2*i], e[i][15:8]);
      cmp8(partner_u.got[2*i+1], e[i][7:0]);
    end
  endtask : rd
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // cut a hang short well past the expected run
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    slow = 1'b0;
    status = '0;
    status.level_closed = 1'b1;
    status.level_percent = 16'h0033;
    status.pressure_is_loop = 1'b1;
    status.pressure_percent = 16'h0042;
    {status.pilot_on, status.first_safety_valve, status.second_safety_valve, status.high_fire} = 4'hf;
    status.aux_percent = 16'h0064;
    status.shutdown_code = 16'h0123;
    status.temp_unit_f = 1'b1;
    {process_temp, process_sp, low_fire_sp} = {16'hffce, 16'h0546, 16'h0000};
    {pilot_off_sp, low_temp_sp, high_temp_sp} = {16'h0123, 16'h0010, 16'h0500};
    {temp_wr, temp_idx, temp_val} = '0;
    pilot_flame = {16'h0010, 16'h0064, 16'h0020, 16'h0005};
    main_flame = {16'h0020, 16'h0030, 16'h0010, 16'h0005};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // first and last temperature input slots
    {temp_wr, temp_idx, temp_val} <= {1'b1, 5'h00, 16'hffce};
    @(posedge clock);
    {temp_idx, temp_val} <= {5'h13, 16'h0546};
    @(posedge clock);
    temp_wr <= 1'b0;
    repeat (2) @(posedge clock);
    rd(`BRM_FC_READ_INPUT, 16'h0003, {16'hffce});
    rd(`BRM_FC_READ_HOLDING, 16'h0003, {16'hffce});
    slow <= 1'b1;
    rd(`BRM_FC_READ_HOLDING, 16'h0007, {16'h0546, 16'h0000, 16'h0123, 16'h0001, 16'h0042});
    rd(`BRM_FC_READ_INPUT, 16'h0010, {16'h0010, 16'h0500, 16'h0000});
    rd(`BRM_FC_READ_INPUT, 16'h0013, {16'hffce});
    rd(`BRM_FC_READ_HOLDING, 16'h0026, {16'h0546, 16'h0030, 16'h0055, 16'h0064, 16'h0123});
    rd(`BRM_FC_READ_INPUT, 16'h0005, {16'h0064});
    $display("map reads done");
    slow <= 1'b0;
    rd(`BRM_FC_READ_INPUT, 16'h0000, {16'h0000});
    for (int i = 0; i < 3; i++) begin
      {status.firing, status.relighting, status.relight_wait} <= 3'h4 >> i;
      @(posedge clock);
      rd(`BRM_FC_READ_INPUT, 16'h0000, {16'h0001});
      rd(`BRM_FC_READ_HOLDING, 16'h002a, {16'h0000});
    end
    {status.relight_wait, status.shutdown_acked} <= 2'h1;
    @(posedge clock);
    rd(`BRM_FC_READ_INPUT, 16'h002a, {16'h0000});
    cmp8({7'h00, temp_unit_f}, 8'h01);
    {status.level_is_loop, status.pressure_is_loop, status.temp_unit_f} <= 3'h4;
    {status.pilot_on, status.first_safety_valve, status.second_safety_valve, status.high_fire} <= 4'h4;
    @(posedge clock);
    cmp8({7'h00, temp_unit_f}, 8'h00);
    rd(`BRM_FC_READ_HOLDING, 16'h000a, {16'h0033, 16'h0000});
    rd(`BRM_FC_READ_INPUT, 16'h0028, {16'h0004});
    $display("run state reads done");
    // a write function and a zero count are both refused
    partner_u.read(8'h06, 16'h0003, 8'h01);
    cmp8({7'h00, partner_u.rej_seen}, 8'h01);
    partner_u.read(`BRM_FC_READ_INPUT, 16'h0003, 8'h00);
    cmp8({7'h00, partner_u.rej_seen}, 8'h01);
    rd(`BRM_FC_READ_INPUT, 16'h0003, {16'hffce});
    $display("refusal tests done");
    summarize();
  end
endmodule : testbench

// *** verilog/brm_params.svh ***
`ifndef BRM_PARAMS_SVH
`define BRM_PARAMS_SVH
// function codes of the read requests
`define BRM_FC_READ_HOLDING 8'h03
`define BRM_FC_READ_INPUT   8'h04
// register offsets
`define BRM_OFS_RUN_STATE       6'h00
`define BRM_OFS_PROCESS_TEMP    6'h03
`define BRM_OFS_PILOT_FLAME     6'h05
`define BRM_OFS_PROCESS_SP      6'h07
`define BRM_OFS_LOW_FIRE_SP     6'h08
`define BRM_OFS_PILOT_OFF_SP    6'h09
`define BRM_OFS_LEVEL_INPUT     6'h0a
`define BRM_OFS_PRESSURE_INPUT  6'h0b
`define BRM_OFS_LOW_TEMP_SP     6'h10
`define BRM_OFS_HIGH_TEMP_SP    6'h11
`define BRM_OFS_TEMP_FIRST      6'h13
`define BRM_OFS_TEMP_LAST       6'h26
`define BRM_OFS_MAIN_FLAME      6'h27
`define BRM_OFS_VALVE_BITS      6'h28
`define BRM_OFS_AUX_PERCENT     6'h29
`define BRM_OFS_SHUTDOWN        6'h2a
`define BRM_OFS_LAST            6'h2a
// valve bitmap positions
`define BRM_VALVE_PILOT_BIT     0
`define BRM_VALVE_SSV_A_BIT     2
`define BRM_VALVE_SSV_B_BIT     4
`define BRM_VALVE_HIGH_FIRE_BIT 6
// value limits
`define BRM_FLAME_FULL          16'h0064
`define BRM_SWITCH_CLOSED       16'h0001
`define BRM_SWITCH_OPEN         16'h0000
`define BRM_NUM_TEMPS           20
`define BRM_NUM_PILOTS          4
`define BRM_REG_DEPTH           64
`endif

// *** verilog/brm_pkg.sv ***
package brm_pkg;
  // read request from the frame engine
  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] start;
    logic [7:0]  count;
  } brm_req_type;

  // one answer byte
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } brm_byte_type;

  // live burner controller state
  typedef struct packed {
    logic        firing;
    logic        relighting;
    logic        relight_wait;
    logic        temp_unit_f;
    logic        level_is_loop;
    logic        level_closed;
    logic [15:0] level_percent;
    logic        pressure_is_loop;
    logic        pressure_closed;
    logic [15:0] pressure_percent;
    logic        pilot_on;
    logic        first_safety_valve;
    logic        second_safety_valve;
    logic        high_fire;
    logic [15:0] aux_percent;
    logic [15:0] shutdown_code;
    logic        shutdown_acked;
  } brm_status_type;

  typedef enum logic [1:0] {
    BRM_IDLE = 2'b00,
    BRM_NEXT = 2'b01,
    BRM_HIGH = 2'b11,
    BRM_LOW  = 2'b10
  } brm_state_type;
endpackage : brm_pkg

// *** verilog/brm_reg_mem.sv ***
`timescale 1ns/10ps
// small shadow store for the temperature readings, registered read
module brm_reg_mem #(
  parameter int DEPTH = 20,
  parameter int AW    = 5
) (
  // clock
  input  wire logic          clock,
  // write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [15:0]   wr_data,
  // read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [15:0]   rd_data
);
  logic [15:0] mem [DEPTH];

  // memory holds no reset; read data registered for timing
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : brm_reg_mem

// *** verilog/brm_register_bank.sv ***
`timescale 1ns/10ps
`include "brm_params.svh"
// Contract
// - registers are two-byte, read only
// - input and holding spaces return same values
// - function 0x04 reads input registers
// - function 0x03 reads holding mirror
// - single read: high byte then low
// - multi read: ascending offsets, two bytes each
// - offset 3 process temperature, signed
// - setpoints at 7,8,9,16,17 signed
// - offset 5 pilot flame, any full wins
// - offset 39 main flame, any full wins
// - offset 10 level: switch or percent
// - offset 11 pressure: switch or percent
// - offsets 19-38 temperature inputs in order
// - offset 40 valve bitmap, odd bits zero
// - offset 41 aux output percent
// - offset 42 shutdown code, zero when clear
// - offset 0 run state firing or relight
// - temperatures follow selected unit
module brm_register_bank #(
  parameter int NUM_TEMPS  = `BRM_NUM_TEMPS,
  parameter int NUM_PILOTS = `BRM_NUM_PILOTS
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // request from frame engine
  input  wire logic                       req_valid,
  input  brm_pkg::brm_req_type            req,
  output logic                            req_ready,
  output logic                            req_reject,
  // answer byte stream
  output brm_pkg::brm_byte_type           rsp,
  input  wire logic                       rsp_ready,
  // controller status
  input  brm_pkg::brm_status_type         status,
  // temperatures, already in the selected unit
  input  wire logic [15:0]                process_temp,
  input  wire logic [15:0]                process_sp,
  input  wire logic [15:0]                low_fire_sp,
  input  wire logic [15:0]                pilot_off_sp,
  input  wire logic [15:0]                low_temp_sp,
  input  wire logic [15:0]                high_temp_sp,
  // temperature input stream, one per update
  input  wire logic                       temp_wr,
  input  wire logic [4:0]                 temp_idx,
  input  wire logic [15:0]                temp_val,
  // flame quality per pilot module
  input  wire logic [NUM_PILOTS*16-1:0]   pilot_flame,
  input  wire logic [NUM_PILOTS*16-1:0]   main_flame,
  // live unit flag for the frame engine
  output logic                            temp_unit_f
);
  import brm_pkg::*;

  brm_state_type state_reg;
  brm_state_type state_next;
  logic [15:0]   addr_reg;
  logic [7:0]    left_reg;
  logic [15:0]   word_reg;
  logic [15:0]   word_next;
  logic [15:0]   mem_rd;
  logic          mem_pend_reg;
  logic [15:0]   pilot_q_reg;
  logic [15:0]   main_q_reg;
  logic [7:0]    byte_reg;
  logic          last_reg;

  // run state: firing, relighting or waiting to relight
  function automatic logic run_active(input brm_status_type s);
    return s.firing | s.relighting | s.relight_wait;
  endfunction : run_active

  // flame quality: any module at full wins, else the best one
  function automatic logic [15:0] flame_merge(input logic [NUM_PILOTS*16-1:0] v);
    logic [15:0] best;
    best = 16'h0000;
    for (int i = 0; i < NUM_PILOTS; i++) begin
      if (v[i*16 +: 16] >= `BRM_FLAME_FULL) begin
        best = `BRM_FLAME_FULL;
      end else if (v[i*16 +: 16] > best && best != `BRM_FLAME_FULL) begin
        best = v[i*16 +: 16];
      end
    end
    return best;
  endfunction : flame_merge

  // switch or loop reading for level and pressure
  function automatic logic [15:0] input_value(input logic is_loop, input logic closed,
                                              input logic [15:0] pct);
    if (is_loop) begin
      return pct;
    end
    return closed ? `BRM_SWITCH_CLOSED : `BRM_SWITCH_OPEN;
  endfunction : input_value

  // both function codes are served from the same map
  function automatic logic func_ok(input logic [7:0] f);
    return (f == `BRM_FC_READ_INPUT) || (f == `BRM_FC_READ_HOLDING);
  endfunction : func_ok

  // temperature slot inside the configured count; unused slots never written
  function automatic logic slot_ok(input logic [5:0] idx);
    return int'(idx) < NUM_TEMPS;
  endfunction : slot_ok

  // flame merge is registered to keep the compare chain out of the read path
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pilot_q_reg <= 16'h0000;
      main_q_reg  <= 16'h0000;
    end else begin
      pilot_q_reg <= flame_merge(pilot_flame);
      main_q_reg  <= flame_merge(main_flame);
    end
  end

  assign temp_unit_f = status.temp_unit_f;

  // temperature inputs kept in configured order, first at lowest offset
  brm_reg_mem #(
    .DEPTH (NUM_TEMPS),
    .AW    (5)
  ) u_temps (
    .clock   (clock),
    .wr_en   (temp_wr && slot_ok({1'b0, temp_idx})),
    .wr_addr (temp_idx),
    .wr_data (temp_val),
    .rd_addr (5'(addr_reg - 16'(`BRM_OFS_TEMP_FIRST))),
    .rd_data (mem_rd)
  );

  // map decode; reads never change any stored value
  always_comb begin
    word_next = 16'h0000;
    if (addr_reg[15:6] == 10'h000) begin
      case (addr_reg[5:0])
        `BRM_OFS_RUN_STATE:      word_next = {15'h0000, run_active(status)};
        `BRM_OFS_PROCESS_TEMP:   word_next = process_temp;
        `BRM_OFS_PILOT_FLAME:    word_next = pilot_q_reg;
        `BRM_OFS_PROCESS_SP:     word_next = process_sp;
        `BRM_OFS_LOW_FIRE_SP:    word_next = low_fire_sp;
        `BRM_OFS_PILOT_OFF_SP:   word_next = pilot_off_sp;
        `BRM_OFS_LEVEL_INPUT:    word_next = input_value(status.level_is_loop, status.level_closed,
                                                         status.level_percent);
        `BRM_OFS_PRESSURE_INPUT: word_next = input_value(status.pressure_is_loop,
                                                         status.pressure_closed,
                                                         status.pressure_percent);
        `BRM_OFS_LOW_TEMP_SP:    word_next = low_temp_sp;
        `BRM_OFS_HIGH_TEMP_SP:   word_next = high_temp_sp;
        `BRM_OFS_MAIN_FLAME:     word_next = main_q_reg;
        `BRM_OFS_VALVE_BITS: begin
          word_next[`BRM_VALVE_PILOT_BIT]     = status.pilot_on;
          word_next[`BRM_VALVE_SSV_A_BIT]     = status.first_safety_valve;
          word_next[`BRM_VALVE_SSV_B_BIT]     = status.second_safety_valve;
          word_next[`BRM_VALVE_HIGH_FIRE_BIT] = status.high_fire;
        end
        `BRM_OFS_AUX_PERCENT:    word_next = status.aux_percent;
        `BRM_OFS_SHUTDOWN: begin
          // cleared while running or once acknowledged
          if (!run_active(status) && !status.shutdown_acked) begin
            word_next = status.shutdown_code;
          end
        end
        default: begin
          if (addr_reg[5:0] >= `BRM_OFS_TEMP_FIRST && addr_reg[5:0] <= `BRM_OFS_TEMP_LAST
              && slot_ok(addr_reg[5:0] - `BRM_OFS_TEMP_FIRST)) begin
            word_next = mem_rd;
          end
        end
      endcase
    end
  end

  // request acceptance only when idle; other function codes bounced
  assign req_ready  = (state_reg == BRM_IDLE);
  assign req_reject = req_valid && req_ready && (!func_ok(req.func) || req.count == 8'h00);

  // byte sequencer: high byte, low byte, then next offset
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BRM_IDLE: begin
        if (req_valid && func_ok(req.func) && req.count != 8'h00) begin
          state_next = BRM_NEXT;
        end
      end
      BRM_NEXT: begin
        if (!mem_pend_reg) begin
          state_next = BRM_HIGH;
        end
      end
      BRM_HIGH: begin
        if (rsp_ready) begin
          state_next = BRM_LOW;
        end
      end
      BRM_LOW: begin
        if (rsp_ready) begin
          state_next = (left_reg == 8'h01) ? BRM_IDLE : BRM_NEXT;
        end
      end
      default: state_next = BRM_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= BRM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // one wait cycle so the registered memory read has landed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_pend_reg <= 1'b0;
    end else begin
      mem_pend_reg <= (state_next == BRM_NEXT) && (state_reg != BRM_NEXT);
    end
  end

  // address walks upward one register per word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_reg <= 16'h0000;
      left_reg <= 8'h00;
    end else if (state_reg == BRM_IDLE && state_next == BRM_NEXT) begin
      addr_reg <= req.start;
      left_reg <= req.count;
    end else if (state_reg == BRM_LOW && rsp_ready && left_reg != 8'h01) begin
      addr_reg <= addr_reg + 16'h0001;
      left_reg <= left_reg - 8'h01;
    end
  end

  // word captured before its two bytes go out
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      word_reg <= 16'h0000;
    end else if (state_reg == BRM_NEXT && !mem_pend_reg) begin
      word_reg <= word_next;
    end
  end

  // outgoing byte kept in a flop: high half at capture, low half once the high is taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      byte_reg <= 8'h00;
    end else if (state_reg == BRM_NEXT && !mem_pend_reg) begin
      byte_reg <= word_next[15:8];
    end else if (state_reg == BRM_HIGH && rsp_ready) begin
      byte_reg <= word_reg[7:0];
    end
  end

  // last flag rides with the final low byte, so a stall cannot glitch it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_reg <= 1'b0;
    end else if (state_reg == BRM_HIGH && rsp_ready) begin
      last_reg <= (left_reg == 8'h01);
    end else if (state_reg == BRM_LOW && rsp_ready) begin
      last_reg <= 1'b0;
    end
  end

  // answer byte from flip-flops; only valid decodes the state
  always_comb begin
    rsp.valid = (state_reg == BRM_HIGH) || (state_reg == BRM_LOW);
    rsp.last  = last_reg;
    rsp.data  = byte_reg;
  end
endmodule : brm_register_bank
